// file: shared/swgfp_map.svh
// Register indices, field positions, reset values and frame limits
`ifndef SWGFP_MAP_SVH
`define SWGFP_MAP_SVH

// Register indices; byte address is four times the index
`define SWGFP_IDX_CTRL2   8'h04
`define SWGFP_IDX_CTRL3   8'h05
`define SWGFP_IDX_FRAMES  8'h08
`define SWGFP_IDX_DROPS   8'h09

// Control 2 fields
`define SWGFP_C2_STORM_MC 6
`define SWGFP_C2_FAIR     4
`define SWGFP_C2_XCOL     3
`define SWGFP_C2_SIZE_DIS 1
`define SWGFP_C2_RESET    8'h50
`define SWGFP_C2_WMASK    8'h5a

// Control 3 fields
`define SWGFP_C3_VLAN     7
`define SWGFP_C3_IGMP     6
`define SWGFP_C3_RESET    8'h00
`define SWGFP_C3_WMASK    8'hc0

// Frame limits in bytes: 1518, 1522, 1536; collision limit 16
`define SWGFP_MAX_UNTAG   11'h5ee
`define SWGFP_MAX_TAG     11'h5f2
`define SWGFP_MAX_ANY     11'h600
`define SWGFP_XCOL_LIMIT  5'h10

`endif

// file: shared/swgfp_pkg.sv
// Types shared by the forwarding policy modules
package swgfp_pkg;

    // One frame descriptor as it enters the policy stage
    typedef struct packed {
        logic [10:0] len;
        logic        is_tagged;
        logic        spec_tag;
        logic        da_bcast;
        logic        da_mcast;
        logic        igmp;
        logic        src_fc;
        logic        dst_shared;
        logic [4:0]  coll;
    } swgfp_desc_t;

    // Why a frame was dropped
    typedef enum logic [1:0] {
        RSN_NONE = 2'b00,
        RSN_SIZE = 2'b01,
        RSN_XCOL = 2'b10,
        RSN_FAIR = 2'b11
    } swgfp_reason_t;

endpackage : swgfp_pkg

// file: shared/swgfp_cfg_if.sv
// Control bits and status counts between register slave and core
`timescale 1ns/10ps
`default_nettype none
interface swgfp_cfg_if;
    logic        storm_mc_only;
    logic        fair;
    logic        xcol_keep;
    logic        size_dis;
    logic        vlan_en;
    logic        igmp_snoop;
    logic [15:0] frame_cnt;
    logic [15:0] drop_cnt;

    modport regs (output storm_mc_only, fair, xcol_keep, size_dis,
                  output vlan_en, igmp_snoop, input frame_cnt, drop_cnt);
    modport core (input storm_mc_only, fair, xcol_keep, size_dis,
                  input vlan_en, igmp_snoop, output frame_cnt, drop_cnt);
endinterface : swgfp_cfg_if
`default_nettype wire

// file: logic/swgfp_fifo.sv
// Descriptor FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module swgfp_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Filling side
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem_q[rp_q];
    assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // Pointers, fill count and registered flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q      <= '0;
            rp_q      <= '0;
            cnt_q     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q     <= cnt_d;
            in_ready  <= (cnt_d != (AW+1)'(D));
            out_valid <= (cnt_d != '0);
        end
    end
endmodule : swgfp_fifo
`default_nettype wire

// file: logic/swgfp_regs.sv
// APB slave holding the global policy control registers
`timescale 1ns/10ps
`default_nettype none
`include "swgfp_map.svh"
module swgfp_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Controls toward the core
    swgfp_cfg_if.regs        cfg
);
    logic [7:0]  ctrl2_q;
    logic [7:0]  ctrl3_q;
    logic        hit;
    logic [31:0] rd_d;
    logic        setup;
    logic        wr_fire;

    assign setup   = psel && !penable;
    assign wr_fire = psel && penable && pready && pwrite && !pslverr;

    // Address decode and read mux
    always_comb begin
        hit  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
        rd_d = 32'h0;
        case (paddr[9:2])
            `SWGFP_IDX_CTRL2:  rd_d = {24'h0, ctrl2_q};
            `SWGFP_IDX_CTRL3:  rd_d = {24'h0, ctrl3_q};
            `SWGFP_IDX_FRAMES: rd_d = {16'h0, cfg.frame_cnt};
            `SWGFP_IDX_DROPS:  rd_d = {16'h0, cfg.drop_cnt};
            default:           hit  = 1'b0;
        endcase
    end

    // Answer one cycle after setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit;
            prdata  <= (setup && !pwrite) ? rd_d : 32'h0;
        end
    end

    // Control writes; reserved bits stay zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl2_q <= `SWGFP_C2_RESET;
            ctrl3_q <= `SWGFP_C3_RESET;
        end else if (wr_fire) begin
            if (paddr[9:2] == `SWGFP_IDX_CTRL2) begin
                ctrl2_q <= pwdata[7:0] & `SWGFP_C2_WMASK;
            end
            if (paddr[9:2] == `SWGFP_IDX_CTRL3) begin
                ctrl3_q <= pwdata[7:0] & `SWGFP_C3_WMASK;
            end
        end
    end

    // Control bits toward the core
    assign cfg.storm_mc_only = ctrl2_q[`SWGFP_C2_STORM_MC];
    assign cfg.fair          = ctrl2_q[`SWGFP_C2_FAIR];
    assign cfg.xcol_keep     = ctrl2_q[`SWGFP_C2_XCOL];
    assign cfg.size_dis      = ctrl2_q[`SWGFP_C2_SIZE_DIS];
    assign cfg.vlan_en       = ctrl3_q[`SWGFP_C3_VLAN];
    assign cfg.igmp_snoop    = ctrl3_q[`SWGFP_C3_IGMP];
endmodule : swgfp_regs
`default_nettype wire

// file: logic/swgfp_top.sv
// Global forwarding policy core: descriptor FIFO, decisions, registers
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "swgfp_map.svh"

module swgfp_top
    import swgfp_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    // APB register bus
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    // Frame descriptor in
    input  wire logic        FRM_VALID,
    output var  logic        FRM_READY,
    input  wire logic [10:0] FRM_LEN,
    input  wire logic        FRM_TAGGED,
    input  wire logic        FRM_SPECIAL_TAG,
    input  wire logic        FRM_DA_BCAST,
    input  wire logic        FRM_DA_MCAST,
    input  wire logic        FRM_IGMP,
    input  wire logic        FRM_SRC_FC,
    input  wire logic        FRM_DST_SHARED,
    input  wire logic [4:0]  FRM_COLL_CNT,
    // Decision out
    output var  logic        RES_VALID,
    input  wire logic        RES_READY,
    output var  logic        RES_DROP,
    output var  logic [1:0]  RES_REASON,
    output var  logic        RES_STORM,
    output var  logic        RES_PAUSE_SRC,
    output var  logic        RES_RETRY,
    output var  logic        RES_VLAN,
    output var  logic        RES_TO_HOST
);
    localparam int DW = $bits(swgfp_desc_t);

    swgfp_cfg_if   cfg ();
    swgfp_desc_t   in_desc;
    swgfp_desc_t   head;
    logic [DW-1:0] head_bits;
    logic          head_valid;
    logic          take;
    logic          pop;

    // Decision terms for the head descriptor
    logic          storm_d;
    logic          size_bad;
    logic          xcol_bad;
    logic          fair_bad;
    logic          pause_d;
    logic          retry_d;
    swgfp_reason_t reason_d;
    logic [10:0]   len_lim;

    // Registered decision and counts
    logic          res_valid_q;
    logic          res_drop_q;
    swgfp_reason_t res_reason_q;
    logic          res_storm_q;
    logic          res_pause_q;
    logic          res_retry_q;
    logic          res_vlan_q;
    logic          res_host_q;
    logic [15:0]   frame_cnt_q;
    logic [15:0]   drop_cnt_q;

    // Register slave
    swgfp_regs u_regs (
        .clk     (SYS_CLK),
        .rst_n   (RESETN),
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pwdata  (PWDATA),
        .prdata  (PRDATA),
        .pready  (PREADY),
        .pslverr (PSLVERR),
        .cfg     (cfg.regs)
    );

    // Pack incoming descriptor fields
    always_comb begin
        in_desc.len        = FRM_LEN;
        in_desc.is_tagged  = FRM_TAGGED;
        in_desc.spec_tag   = FRM_SPECIAL_TAG;
        in_desc.da_bcast   = FRM_DA_BCAST;
        in_desc.da_mcast   = FRM_DA_MCAST;
        in_desc.igmp       = FRM_IGMP;
        in_desc.src_fc     = FRM_SRC_FC;
        in_desc.dst_shared = FRM_DST_SHARED;
        in_desc.coll       = FRM_COLL_CNT;
    end

    // Sixteen-deep descriptor buffer; full stalls FRM_READY
    swgfp_fifo #(
        .W (DW),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst_n     (RESETN),
        .in_valid  (FRM_VALID),
        .in_ready  (FRM_READY),
        .in_data   (in_desc),
        .out_valid (head_valid),
        .out_ready (take),
        .out_data  (head_bits)
    );

    assign head = swgfp_desc_t'(head_bits);
    // Output stage empty or being drained
    assign take = !res_valid_q || RES_READY;
    assign pop  = head_valid && take;

    // Size limit for the head frame
    always_comb begin
        len_lim = `SWGFP_MAX_UNTAG;
        // disable widens every frame to 1536
        if (cfg.size_dis) begin
            len_lim = `SWGFP_MAX_ANY;
        // special-tagged frames skip the tagged limit
        end else if (head.is_tagged && head.spec_tag) begin
            len_lim = `SWGFP_MAX_ANY;
        end else if (head.is_tagged) begin
            len_lim = `SWGFP_MAX_TAG;
        end
    end

    // Policy decision for the head frame
    always_comb begin
        storm_d  = head.da_bcast || (head.da_mcast && !cfg.storm_mc_only);
        size_bad = head.len > len_lim;
        // drop at 16 collisions unless retry kept
        xcol_bad = (head.coll >= `SWGFP_XCOL_LIMIT) && !cfg.xcol_keep;
        retry_d  = (head.coll != 5'h0) && !xcol_bad;
        // fair mode sheds the non-flow-control source
        fair_bad = cfg.fair && !head.src_fc && head.dst_shared;
        // otherwise flow control holds the flow-control source
        pause_d  = !cfg.fair && head.src_fc && head.dst_shared;
        if (size_bad) begin
            reason_d = RSN_SIZE;
        end else if (xcol_bad) begin
            reason_d = RSN_XCOL;
        end else if (fair_bad) begin
            reason_d = RSN_FAIR;
        end else begin
            reason_d = RSN_NONE;
        end
    end

    // Output handshake
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            res_valid_q <= 1'b0;
        end else if (take) begin
            res_valid_q <= head_valid;
        end
    end

    // Decision fields, loaded on each pop
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            res_drop_q   <= 1'b0;
            res_reason_q <= RSN_NONE;
            res_storm_q  <= 1'b0;
            res_pause_q  <= 1'b0;
            res_retry_q  <= 1'b0;
            res_vlan_q   <= 1'b0;
            res_host_q   <= 1'b0;
        end else if (pop) begin
            res_drop_q   <= (reason_d != RSN_NONE);
            res_reason_q <= reason_d;
            res_storm_q  <= storm_d;
            res_pause_q  <= pause_d;
            res_retry_q  <= retry_d;
            // VLAN handling follows the enable bit
            res_vlan_q   <= cfg.vlan_en;
            // surviving IGMP frames go to the host port
            res_host_q   <= cfg.igmp_snoop && head.igmp && (reason_d == RSN_NONE);
        end
    end

    // Frame and drop counters for software
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            frame_cnt_q <= 16'h0;
            drop_cnt_q  <= 16'h0;
        end else if (pop) begin
            frame_cnt_q <= frame_cnt_q + 16'h1;
            if (reason_d != RSN_NONE) begin
                drop_cnt_q <= drop_cnt_q + 16'h1;
            end
        end
    end

    assign cfg.frame_cnt = frame_cnt_q;
    assign cfg.drop_cnt  = drop_cnt_q;

    // Ports straight from the decision flops
    assign RES_VALID     = res_valid_q;
    assign RES_DROP      = res_drop_q;
    assign RES_REASON    = res_reason_q;
    assign RES_STORM     = res_storm_q;
    assign RES_PAUSE_SRC = res_pause_q;
    assign RES_RETRY     = res_retry_q;
    assign RES_VLAN      = res_vlan_q;
    assign RES_TO_HOST   = res_host_q;

    // Checks on the decision stage
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    property p_storm;
        pop |=> RES_STORM == ($past(head.da_bcast)
            || ($past(head.da_mcast) && !$past(cfg.storm_mc_only)));
    endproperty
    a_storm: assert property (p_storm) else $error("storm class wrong");

    property p_fair_drop;
        pop && cfg.fair && !head.src_fc && head.dst_shared && !size_bad && !xcol_bad
            |=> RES_DROP && RES_REASON == RSN_FAIR && !RES_PAUSE_SRC;
    endproperty
    a_fair_drop: assert property (p_fair_drop) else $error("fair drop missing");

    property p_fc_pause;
        pop && !cfg.fair && head.src_fc && head.dst_shared
            |=> RES_PAUSE_SRC && RES_REASON != RSN_FAIR;
    endproperty
    a_fc_pause: assert property (p_fc_pause) else $error("source not paused");

    property p_xcol;
        pop && head.coll >= 5'h10 && !size_bad
            |=> (RES_REASON == RSN_XCOL) == !$past(cfg.xcol_keep)
                && RES_RETRY == $past(cfg.xcol_keep);
    endproperty
    a_xcol: assert property (p_xcol) else $error("collision policy wrong");

    property p_size_dis;
        pop && cfg.size_dis |=> (RES_REASON == RSN_SIZE) == ($past(head.len) > 11'h600);
    endproperty
    a_size_dis: assert property (p_size_dis) else $error("1536 limit wrong");

    property p_size_chk;
        pop && !cfg.size_dis && !head.is_tagged
            |=> (RES_REASON == RSN_SIZE) == ($past(head.len) > 11'h5ee);
    endproperty
    a_size_chk: assert property (p_size_chk) else $error("1518 limit wrong");

    property p_size_tag;
        pop && !cfg.size_dis && head.is_tagged && !head.spec_tag
            |=> (RES_REASON == RSN_SIZE) == ($past(head.len) > 11'h5f2);
    endproperty
    a_size_tag: assert property (p_size_tag) else $error("1522 limit wrong");

    property p_vlan;
        pop ##1 1'b1 |-> RES_VALID && RES_VLAN == $past(cfg.vlan_en);
    endproperty
    a_vlan: assert property (p_vlan) else $error("vlan flag wrong");

    property p_igmp;
        pop && cfg.igmp_snoop && head.igmp |=> RES_TO_HOST == !RES_DROP;
    endproperty
    a_igmp: assert property (p_igmp) else $error("igmp not redirected");

    property p_hold;
        RES_VALID && !RES_READY |=> RES_VALID && $stable(RES_REASON) && $stable(RES_TO_HOST);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed under stall");

    property p_c_storm;
        pop && head.da_mcast && !head.da_bcast ##1 RES_STORM;
    endproperty
    c_storm: cover property (p_c_storm);

    property p_c_fair;
        RES_VALID && RES_REASON == RSN_FAIR;
    endproperty
    c_fair: cover property (p_c_fair);

    property p_c_host;
        RES_VALID && RES_TO_HOST && RES_VLAN;
    endproperty
    c_host: cover property (p_c_host);

    property p_c_full;
        !FRM_READY ##1 FRM_READY;
    endproperty
    c_full: cover property (p_c_full);
endmodule : swgfp_top
`default_nettype wire

// file: bench/swgfp_sink.sv
// Decision consumer standing downstream of the policy stage
`timescale 1ns/10ps
`default_nettype none
module swgfp_sink (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Behaviour select
    input  wire logic slow,
    input  wire logic hold,
    // Decision handshake
    output var  logic res_ready
);
    int seed = 69;

    // Ready: prompt, random stalls, or held off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_ready <= 1'b0;
        end else if (hold) begin
            res_ready <= 1'b0;
        end else if (slow) begin
            res_ready <= (($random(seed) & 3) == 0);
        end else begin
            res_ready <= 1'b1;
        end
    end
endmodule : swgfp_sink
`default_nettype wire

// file: bench/swgfp_top_tb.sv
// Self-checking bench for the forwarding policy top
`timescale 1ns/10ps
`default_nettype none
`include "swgfp_map.svh"
module swgfp_top_tb
    import swgfp_pkg::*;
;
    logic        clk, rstn, psel, penable, pwrite, frm_valid, frm_ready, res_ready;
    logic        slow, hold, sd, sf, sx, ss, c_vlan, c_igmp, err, rdy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic        pready, pslverr, r_drop, r_storm, r_pause, r_retry, r_vlan, r_host, r_valid;
    logic [1:0]  r_rsn;
    swgfp_desc_t d;
    logic [15:0] q[$];
    int          seed, fail_count, total_checks, n, n_drop;

    swgfp_top swgfp_top_inst (.SYS_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FRM_VALID(frm_valid), .FRM_READY(frm_ready), .FRM_LEN(d.len),
        .FRM_TAGGED(d.is_tagged), .FRM_SPECIAL_TAG(d.spec_tag), .FRM_DA_BCAST(d.da_bcast),
        .FRM_DA_MCAST(d.da_mcast), .FRM_IGMP(d.igmp), .FRM_SRC_FC(d.src_fc),
        .FRM_DST_SHARED(d.dst_shared), .FRM_COLL_CNT(d.coll), .RES_VALID(r_valid),
        .RES_READY(res_ready), .RES_DROP(r_drop), .RES_REASON(r_rsn), .RES_STORM(r_storm),
        .RES_PAUSE_SRC(r_pause), .RES_RETRY(r_retry), .RES_VLAN(r_vlan), .RES_TO_HOST(r_host));

    swgfp_sink swgfp_sink_inst (.clk(clk), .rst_n(rstn), .slow(slow), .hold(hold),
        .res_ready(res_ready));

    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_res(input logic [7:0] e, input logic [7:0] m, input logic [7:0] g);
        total_checks++;
        if ((g & m) !== (e & m)) begin
            fail_count++;
            $display("[FAIL] decision exp %b got %b mask %b", e, g, m);
        end
    endtask : chk_res

    // One APB transfer, then one idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        rdy = 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        // Answer taken at the rising edge that sees pready high
        for (int i = 0; i < 50 && rdy !== 1'b1; i++) begin
            @(posedge clk);
            rdy = pready;
            rd = prdata;
            err = pslverr;
        end
        if (rdy !== 1'b1) chk_reg("apb ready", 1, 0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Expected decision and compare mask for one descriptor
    function automatic logic [15:0] expect_of(swgfp_desc_t x);
        logic [10:0] lim;
        logic [1:0]  rsn;
        logic [7:0]  e;
        logic        xb;
        lim = sd ? `SWGFP_MAX_ANY : (x.is_tagged ? (x.spec_tag ? `SWGFP_MAX_ANY
            : `SWGFP_MAX_TAG) : `SWGFP_MAX_UNTAG);
        // Collision limit reached without keep; no retry even if size drops it first
        xb = !sx && (x.coll >= `SWGFP_XCOL_LIMIT);
        rsn = RSN_NONE;
        if (x.len > lim) rsn = RSN_SIZE;
        else if (xb) rsn = RSN_XCOL;
        else if (sf && !x.src_fc && x.dst_shared) rsn = RSN_FAIR;
        e = {rsn != RSN_NONE, rsn, x.da_bcast | (~ss & x.da_mcast),
             ~sf & x.src_fc & x.dst_shared, (x.coll != 0) && !xb, c_vlan,
             c_igmp & x.igmp & (rsn == RSN_NONE)};
        return {(rsn != RSN_NONE) ? 8'he5 : 8'hff, e};
    endfunction : expect_of

    // Random descriptor with lengths and collisions near the limits
    task automatic send_rand();
        logic [10:0] lens[8];
        logic [4:0]  cols[4];
        swgfp_desc_t x;
        logic [31:0] r;
        logic [15:0] e;
        lens = '{11'h5ee, 11'h5ef, 11'h5f2, 11'h5f3, 11'h600, 11'h601, 11'h040, 11'h7ff};
        cols = '{5'h00, 5'h0f, 5'h10, 5'h1f};
        r = $random(seed);
        x = r[$bits(swgfp_desc_t)-1:0];
        x.len = lens[$unsigned($random(seed)) % 8];
        x.coll = cols[$unsigned($random(seed)) % 4];
        e = expect_of(x);
        if (e[7]) n_drop++;
        q.push_back(e);
        d <= x;
        frm_valid <= 1'b1;
        // Taken at the rising edge that sees frm_ready high
        rdy = 1'b0;
        for (int i = 0; i < 500 && rdy !== 1'b1; i++) begin
            @(posedge clk);
            rdy = frm_ready;
        end
        if (rdy !== 1'b1) chk_reg("frame taken", 1, 0);
    endtask : send_rand

    task automatic drain();
        frm_valid <= 1'b0;
        for (int i = 0; i < 2000 && q.size() != 0; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        chk_reg("pending", 0, q.size());
    endtask : drain

    // Result watcher
    always @(posedge clk) begin
        if (rstn && r_valid === 1'b1 && res_ready === 1'b1) begin
            if (q.size() == 0) chk_reg("extra decision", 0, 1);
            else begin
                n = q.pop_front();
                chk_res(n[7:0], n[15:8], {r_drop, r_rsn, r_storm, r_pause, r_retry, r_vlan,
                    r_host});
            end
        end
    end

    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial begin
        seed = 69;
        {psel, penable, pwrite, paddr, pwdata, frm_valid, slow, hold} = '0;
        d = '0;
        rstn = 1'b0;
        fail_count = 0;
        total_checks = 0;
        n_drop = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h010, 32'h0);
        chk_reg("ctrl2 reset", {24'h0, `SWGFP_C2_RESET}, rd);
        apb(1'b0, 12'h014, 32'h0);
        chk_reg("ctrl3 reset", {24'h0, `SWGFP_C3_RESET}, rd);
        apb(1'b1, 12'h03c, 32'hffffffff);
        chk_reg("unmapped err", 1, err);
        apb(1'b1, 12'h020, 32'h0000ffff);
        chk_reg("counter write err", 0, err);
        // Every combination of the four policy bits
        for (int c = 0; c < 16; c++) begin
            {ss, sf, sx, sd} = c[3:0];
            {c_vlan, c_igmp} = 2'($random(seed));
            slow <= c[0];
            rnd = $random(seed);
            apb(1'b1, 12'h010, {rnd[31:8], rnd[7], ss, rnd[5], sf, sx, rnd[2], sd, rnd[0]});
            apb(1'b0, 12'h010, 32'h0);
            chk_reg("ctrl2 readback", {25'h0, ss, 1'b0, sf, sx, 1'b0, sd, 1'b0}, rd);
            // no table here, enable written last
            apb(1'b1, 12'h014, {24'h0, c_vlan, c_igmp, 6'h3f});
            apb(1'b0, 12'h014, 32'h0);
            chk_reg("ctrl3 readback", {24'h0, c_vlan, c_igmp, 6'h0}, rd);
            repeat (10) send_rand();
            drain();
        end
        // Fill the FIFO against a stalled consumer, then drain it
        hold <= 1'b1;
        fork
            repeat (24) send_rand();
            begin
                for (int i = 0; i < 100 && frm_ready !== 1'b0; i++) @(posedge clk);
                chk_reg("refused when full", 0, frm_ready);
                hold <= 1'b0;
            end
        join
        drain();
        chk_reg("ready after drain", 1, frm_ready);
        // Software counters: 16 passes of 10 frames plus 24 in the fill test
        apb(1'b0, 12'h020, 32'h0);
        chk_reg("frame count", 32'hb8, rd);
        apb(1'b0, 12'h024, 32'h0);
        chk_reg("drop count", n_drop, rd);
        end_sim();
    end
endmodule : swgfp_top_tb
`default_nettype wire
